// ### common/lewu_pkg.sv
// Shared constants, entry layout and state encodings of the lookup entry staging bank.
// Assumes a single 200 MHz clock and register offsets given as register numbers.
package lewu_pkg;

  // Clock rate and aging step
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned AGE_STEP_S = 150;

  // Register numbers on the plain register port
  localparam logic [15:0] OFS_CMD = 16'h1800;
  localparam logic [15:0] OFS_LOWER = 16'h1801;
  localparam logic [15:0] OFS_UPPER = 16'h1802;
  localparam logic [15:0] OFS_STATUS = 16'h18f0;

  // Field positions
  localparam int CMD_MAKE_BIT = 2;
  localparam int STS_PEND_BIT = 0;
  localparam int STS_FULL_BIT = 1;
  localparam int VALID_BIT = 26;
  localparam int OVR_BIT = 25;
  localparam int STATIC_BIT = 24;
  localparam int FLT_BIT = 23;
  localparam int PEN_BIT = 22;
  localparam int PRI_HI = 21;
  localparam int PRI_LO = 19;
  localparam int PORT_HI = 18;
  localparam int PORT_LO = 16;
  localparam int MAC_HI = 15;

  // Reset values and masks
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [31:0] UPPER_WMASK = 32'h07ff_ffff;
  localparam logic [1:0] AGE_FULL = 2'h3;
  localparam logic [1:0] AGE_ONE = 2'h1;
  localparam logic [2:0] PORTS_ALL = 3'h7;
  localparam logic [2:0] PORTS_NONE = 3'h0;

  // One table entry; mac[47:32] are the last 16 address bits
  typedef struct packed {
    logic valid;
    logic age1_ovr;
    logic stat;
    logic age0_flt;
    logic pri_en;
    logic [2:0] pri;
    logic [2:0] port;
    logic [47:0] mac;
  } lewu_entry_type;

  // Destination lookup answer
  typedef struct packed {
    logic hit;
    logic drop;
    logic override;
    logic pri_valid;
    logic [2:0] pri;
    logic [2:0] ports;
  } lewu_result_type;

  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_CHECK = 3'b011,
    ST_COMMIT = 3'b100
  } lewu_state_type;

  typedef enum logic [1:0] {
    OP_MAKE = 2'b00,
    OP_AGE = 2'b01,
    OP_DST = 2'b10,
    OP_SRC = 2'b11
  } lewu_op_type;

  // Staged words to a table entry
  function automatic lewu_entry_type lewu_stage(input logic [31:0] lo, input logic [31:0] up);
    lewu_entry_type e;
    e.valid = up[VALID_BIT];
    e.age1_ovr = up[OVR_BIT];
    e.stat = up[STATIC_BIT];
    e.age0_flt = up[FLT_BIT];
    e.pri_en = up[PEN_BIT];
    e.pri = up[PRI_HI:PRI_LO];
    e.port = up[PORT_HI:PORT_LO];
    e.mac = {up[MAC_HI:0], lo};
    return e;
  endfunction

endpackage

// ### core/lewu_entry_mem.sv
// Entry table storage: one write port, one read port with registered data.
// Assumes the owner clears every word after reset before trusting it.
module lewu_entry_mem
  import lewu_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int WIDTH = 58,
  parameter int AW = 6
)
(
  input wire logic clk,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data_q,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // No reset on the array so it maps onto plain RAM
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Read data land one cycle after the request
  always_ff @(posedge clk)
  begin
    if (rd_en)
    begin
      rd_data_q <= mem_q[rd_addr];
    end
  end

endmodule

// ### core/lewu_port_map.sv
// Decodes the three-bit port association code of an entry into a port mask.
// Purely combinational; the caller registers the result.
module lewu_port_map
  import lewu_pkg::*;
(
  input wire logic [2:0] code,
  output logic [2:0] mask
);

  // Reserved single-port code yields no port at all
  always_comb
  begin
    unique case (code)
      3'h0: mask = 3'h1;
      3'h1: mask = 3'h2;
      3'h2: mask = 3'h4;
      3'h3: mask = PORTS_NONE;
      3'h4: mask = 3'h3;
      3'h5: mask = 3'h5;
      3'h6: mask = 3'h6;
      3'h7: mask = PORTS_ALL;
    endcase
  end

endmodule

// ### core/lewu_bank.sv
// Lookup entry staging registers, manual make command, aging sweep and lookups.
// Assumes a synchronous register port and lookup requesters on the same clock.
//
// Added by the designer: the address-and-strobe port.
module lewu_bank
  import lewu_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int unsigned SEC_CYCLES = CLK_HZ,
  parameter int unsigned STEP_SECONDS = AGE_STEP_S
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata_q,
  input wire logic global_da_pri,
  input wire logic [2:0] port_fwd_state,
  input wire logic [2:0] port_disabled,
  input wire logic dst_req_valid,
  input wire logic [47:0] dst_req_mac,
  output logic dst_req_ready,
  input wire logic src_req_valid,
  input wire logic [47:0] src_req_mac,
  output logic src_req_ready,
  output logic dst_res_valid_q,
  output lewu_result_type dst_res_q
);

  localparam int AW = $clog2(DEPTH);
  localparam int EW = $bits(lewu_entry_type);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
  localparam int MAKE_WAIT = 4 * DEPTH + 8;

  logic rst_sync1_q, rst_n_q;
  logic [31:0] lower_q, upper_q;
  logic make_pend_q, age_pend_q, full_q;
  logic make_done, age_done, make_start;
  logic [31:0] sec_cnt_q;
  logic [15:0] step_cnt_q;
  logic sec_tick, age_tick;
  lewu_state_type state_q;
  lewu_op_type op_q;
  logic [AW-1:0] idx_q, hit_idx_q, free_idx_q;
  logic free_found_q, match_hit_q;
  logic [47:0] key_q;
  logic [EW-1:0] rd_raw;
  lewu_entry_type cur, staged, wr_entry;
  logic rd_en, wr_en, match, last;
  logic [AW-1:0] wr_addr;
  logic [2:0] cur_mask;

  // Reset release through two flops; the first feeds only the second
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_sync1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_sync1_q <= 1'b1;
      rst_n_q <= rst_sync1_q;
    end
  end

  // Staging registers; reserved upper bits never store
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      lower_q <= REG_RESET;
      upper_q <= REG_RESET;
    end
    else if (bus_wr)
    begin
      if (bus_addr == OFS_LOWER)
        lower_q <= bus_wdata;
      if (bus_addr == OFS_UPPER)
        upper_q <= bus_wdata & UPPER_WMASK;
    end
  end

  // Address order: lower word first, upper 16 bits last on the wire
  assign staged = lewu_stage(lower_q, upper_q);

  // Make request; a new request in the finishing cycle is kept
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      make_pend_q <= 1'b0;
    else
      make_pend_q <= (bus_wr && bus_addr == OFS_CMD && bus_wdata[CMD_MAKE_BIT])
                     || (make_pend_q && !make_done);
  end

  // Table full flag, reported until the next make starts
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      full_q <= 1'b0;
    else if (state_q == ST_COMMIT && !match_hit_q && staged.valid && !free_found_q)
      full_q <= 1'b1;
    else if (make_start)
      full_q <= 1'b0;
  end

  // Register read path; unmapped numbers read zero
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      bus_rdata_q <= REG_RESET;
    else if (bus_rd)
    begin
      bus_rdata_q <= REG_RESET;
      unique case (bus_addr)
        OFS_CMD: bus_rdata_q[CMD_MAKE_BIT] <= make_pend_q;
        OFS_LOWER: bus_rdata_q <= lower_q;
        OFS_UPPER: bus_rdata_q <= upper_q;
        OFS_STATUS:
        begin
          bus_rdata_q[STS_PEND_BIT] <= make_pend_q;
          bus_rdata_q[STS_FULL_BIT] <= full_q;
        end
        default: bus_rdata_q <= REG_RESET;
      endcase
    end
  end

  // Aging step divider: seconds, then steps; three steps drain a full timer
  assign sec_tick = (sec_cnt_q == SEC_CYCLES - 1);
  assign age_tick = sec_tick && (step_cnt_q == 16'(STEP_SECONDS - 1));
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      sec_cnt_q <= 32'h0000_0000;
      step_cnt_q <= 16'h0000;
    end
    else
    begin
      sec_cnt_q <= sec_tick ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
      if (age_tick)
        step_cnt_q <= 16'h0000;
      else if (sec_tick)
        step_cnt_q <= step_cnt_q + 16'h0001;
    end
  end

  // Sweep request; a tick in the finishing cycle is kept
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      age_pend_q <= 1'b0;
    else
      age_pend_q <= age_tick || (age_pend_q && !age_done);
  end

  // Arbitration: make, then sweep, then destination, then source lookups
  assign make_start = state_q == ST_IDLE && make_pend_q;
  assign dst_req_ready = state_q == ST_IDLE && !make_pend_q && !age_pend_q;
  assign src_req_ready = dst_req_ready && !dst_req_valid;

  assign cur = lewu_entry_type'(rd_raw);
  assign match = cur.valid && cur.mac == key_q;
  assign last = idx_q == LAST_IDX;
  assign rd_en = state_q == ST_READ;

  // Scanner: one read and one check per slot
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= ST_INIT;
      op_q <= OP_MAKE;
      idx_q <= '0;
      hit_idx_q <= '0;
      free_idx_q <= '0;
      free_found_q <= 1'b0;
      match_hit_q <= 1'b0;
      key_q <= 48'h0000_0000_0000;
    end
    else
    begin
      unique case (state_q)
        ST_INIT:
        begin
          idx_q <= idx_q + AW'(1);
          if (last)
            state_q <= ST_IDLE;
        end
        ST_IDLE:
        begin
          idx_q <= '0;
          free_found_q <= 1'b0;
          match_hit_q <= 1'b0;
          if (make_pend_q)
          begin
            op_q <= OP_MAKE;
            key_q <= staged.mac;
            state_q <= ST_READ;
          end
          else if (age_pend_q)
          begin
            op_q <= OP_AGE;
            state_q <= ST_READ;
          end
          else if (dst_req_valid)
          begin
            op_q <= OP_DST;
            key_q <= dst_req_mac;
            state_q <= ST_READ;
          end
          else if (src_req_valid)
          begin
            op_q <= OP_SRC;
            key_q <= src_req_mac;
            state_q <= ST_READ;
          end
        end
        ST_READ: state_q <= ST_CHECK;
        ST_CHECK:
        begin
          if (op_q == OP_MAKE && !cur.valid && !free_found_q)
          begin
            free_found_q <= 1'b1;
            free_idx_q <= idx_q;
          end
          if (op_q == OP_MAKE && match)
          begin
            match_hit_q <= 1'b1;
            hit_idx_q <= idx_q;
            state_q <= ST_COMMIT;
          end
          else if (op_q != OP_AGE && op_q != OP_MAKE && match)
            state_q <= ST_IDLE;
          else if (last)
            state_q <= (op_q == OP_MAKE) ? ST_COMMIT : ST_IDLE;
          else
          begin
            idx_q <= idx_q + AW'(1);
            state_q <= ST_READ;
          end
        end
        ST_COMMIT: state_q <= ST_IDLE;
      endcase
    end
  end

  assign make_done = state_q == ST_COMMIT;
  assign age_done = state_q == ST_CHECK && op_q == OP_AGE && last;

  // Table write port: clear, age, refresh and make share one port
  always_comb
  begin
    wr_en = 1'b0;
    wr_addr = idx_q;
    wr_entry = cur;
    if (state_q == ST_INIT)
    begin
      wr_en = 1'b1;
      wr_entry = '0;
    end
    else if (state_q == ST_CHECK && op_q == OP_AGE && cur.valid && !cur.stat)
    begin
      wr_en = 1'b1;
      {wr_entry.age1_ovr, wr_entry.age0_flt} = {cur.age1_ovr, cur.age0_flt} - AGE_ONE;
      if ({cur.age1_ovr, cur.age0_flt} <= AGE_ONE)
        wr_entry.valid = 1'b0;
    end
    else if (state_q == ST_CHECK && op_q == OP_SRC && match && !cur.stat)
    begin
      wr_en = 1'b1;
      {wr_entry.age1_ovr, wr_entry.age0_flt} = AGE_FULL;
    end
    else if (state_q == ST_COMMIT)
    begin
      // Invalid staging with no match writes nothing; a hit is overwritten or deleted
      wr_en = match_hit_q || (staged.valid && free_found_q);
      wr_addr = match_hit_q ? hit_idx_q : free_idx_q;
      wr_entry = staged;
    end
  end

  lewu_entry_mem #(
    .DEPTH(DEPTH),
    .WIDTH(EW),
    .AW(AW)
  ) u_mem (
    .clk(clk),
    .rd_en(rd_en),
    .rd_addr(idx_q),
    .rd_data_q(rd_raw),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_entry)
  );

  lewu_port_map u_map (
    .code(cur.port),
    .mask(cur_mask)
  );

  // Destination answer, one pulse per destination lookup
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      dst_res_valid_q <= 1'b0;
      dst_res_q <= '0;
    end
    else
    begin
      dst_res_valid_q <= state_q == ST_CHECK && op_q == OP_DST && (match || last);
      if (state_q == ST_CHECK && op_q == OP_DST)
      begin
        dst_res_q.hit <= match;
        dst_res_q.drop <= match && cur.stat && cur.age0_flt;
        dst_res_q.override <= match && cur.stat && cur.age1_ovr;
        dst_res_q.pri_valid <= match && cur.pri_en && global_da_pri;
        // A miss must not leak the priority of whatever slot was scanned last
        dst_res_q.pri <= (match && cur.pri_en && global_da_pri) ? cur.pri : 3'h0;
        dst_res_q.ports <= match ? (cur_mask & ~port_disabled
          & ((cur.stat && cur.age1_ovr) ? PORTS_ALL : port_fwd_state)) : PORTS_NONE;
      end
    end
  end

  upper_read_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    bus_rd && bus_addr == OFS_UPPER |=> bus_rdata_q[31:27] == 5'h00
      && bus_rdata_q[26:0] == $past(upper_q[26:0]))
    else $error("upper staging read wrong");

  make_finish_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    $rose(make_pend_q) |-> ##[1:MAKE_WAIT] !make_pend_q)
    else $error("make command never finished");

  commit_copy_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    state_q == ST_COMMIT && match_hit_q |-> wr_en && wr_addr == hit_idx_q
      && wr_entry.valid == upper_q[VALID_BIT]
      && wr_entry.mac == {upper_q[MAC_HI:0], lower_q})
    else $error("make did not rewrite the matching entry");

  static_keep_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    state_q == ST_CHECK && cur.stat && (op_q == OP_AGE || op_q == OP_SRC) |-> !wr_en)
    else $error("static entry modified");

  age_step_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    state_q == ST_CHECK && op_q == OP_AGE && cur.valid && !cur.stat
      && {cur.age1_ovr, cur.age0_flt} == AGE_FULL
    |-> wr_en && wr_entry.valid && {wr_entry.age1_ovr, wr_entry.age0_flt} == 2'h2)
    else $error("age timer not decremented");

  age_remove_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    state_q == ST_CHECK && op_q == OP_AGE && cur.valid && !cur.stat
      && {cur.age1_ovr, cur.age0_flt} == AGE_ONE |-> wr_en && !wr_entry.valid)
    else $error("expired entry kept");

  filter_drop_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    state_q == ST_CHECK && op_q == OP_DST && match && cur.stat && cur.age0_flt
    |=> dst_res_valid_q && dst_res_q.drop)
    else $error("filtered address not dropped");

  prio_gate_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    state_q == ST_CHECK && op_q == OP_DST && match
    |=> dst_res_q.pri_valid == $past(cur.pri_en && global_da_pri))
    else $error("priority gating wrong");

  disabled_port_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    state_q == ST_CHECK && op_q == OP_DST |=> (dst_res_q.ports & $past(port_disabled)) == 3'h0)
    else $error("disabled port forwarded");

  reserved_code_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    state_q == ST_CHECK && op_q == OP_DST && match && cur.port == 3'h3
    |=> dst_res_q.ports == PORTS_NONE)
    else $error("reserved port code forwarded");

endmodule

// ### testbench/lewu_bank_tb.sv
// Self-checking bench for the lookup entry staging bank: registers, make command, lookups, aging.
// Assumes the design package and lewu_bank; shortened aging tick of 200 cycles, 8-slot table.
module lewu_bank_tb
  import lewu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int DEPTH = 8;
  localparam logic [31:0] LO = 32'h1234_5601;
  localparam logic [47:0] MAC = {16'hbeef, LO};

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic [31:0] bus_wdata = 32'h0000_0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [31:0] bus_rdata_q;
  logic global_da_pri = 1'b0;
  logic [2:0] port_fwd_state = 3'h7;
  logic [2:0] port_disabled = 3'h0;
  logic dst_req_valid = 1'b0;
  logic [47:0] dst_req_mac = 48'h0;
  logic dst_req_ready;
  logic src_req_valid = 1'b0;
  logic [47:0] src_req_mac = 48'h0;
  logic src_req_ready;
  logic dst_res_valid_q;
  lewu_result_type dst_res_q;
  int fails = 0;
  int n_compared = 0;
  logic [31:0] d;
  logic [15:0] am [5] = '{OFS_CMD, OFS_LOWER, OFS_UPPER, OFS_STATUS, 16'h1234};
  // Expected port masks per association code; 011 is empty
  logic [2:0] pm [8] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7};

  // Tick of 10 cycles x 20 seconds per step keeps aging visible within a thousand cycles
  lewu_bank #(.DEPTH(DEPTH), .SEC_CYCLES(10), .STEP_SECONDS(20)) u_dut (
    .clk(clk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q),
    .global_da_pri(global_da_pri), .port_fwd_state(port_fwd_state),
    .port_disabled(port_disabled), .dst_req_valid(dst_req_valid),
    .dst_req_mac(dst_req_mac), .dst_req_ready(dst_req_ready),
    .src_req_valid(src_req_valid), .src_req_mac(src_req_mac),
    .src_req_ready(src_req_ready), .dst_res_valid_q(dst_res_valid_q), .dst_res_q(dst_res_q)
  );

  // 200 MHz clock
  always #2.5 clk = ~clk;

  task automatic stop_test;
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask

  // Upper word from flags {valid, age1/override, static, age0/filter, priority enable}
  function automatic logic [31:0] upw(logic [4:0] f, logic [2:0] p, logic [2:0] c,
                                      logic [15:0] m);
    return {5'h00, f, p, c, m};
  endfunction

  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  // Read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    v = bus_rdata_q;
  endtask

  // Stage both words, fire make, then poll pending under a bound
  task automatic make(input logic [31:0] up, input logic [47:0] m);
    logic [31:0] s;
    wr(OFS_UPPER, up);
    wr(OFS_LOWER, m[31:0]);
    wr(OFS_CMD, 32'h0000_0004);
    rd(OFS_STATUS, s);
    chk("make pending", 32'h1, {31'h0, s[STS_PEND_BIT]});
    for (int i = 0; i < 100 && s[STS_PEND_BIT] !== 1'b0; i++)
      rd(OFS_STATUS, s);
    chk("make done", 32'h0, {31'h0, s[STS_PEND_BIT]});
  endtask

  // Request is held until ready is seen high at a rising edge
  task automatic look(input logic [47:0] m, input logic [11:0] e, input bit full);
    int n;
    lewu_result_type r;
    n = 0;
    @(posedge clk);
    dst_req_mac <= m;
    dst_req_valid <= 1'b1;
    #1;
    while (dst_req_ready !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    dst_req_valid <= 1'b0;
    #1;
    n = 0;
    while (dst_res_valid_q !== 1'b1 && n < 60)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    r = dst_res_q;
    if (n >= 60)
      chk("lookup answer", 32'h1, 32'h0);
    else if (full)
      chk("lookup result", {20'h0, e}, {20'h0, r});
    else
      chk("lookup hit", {31'h0, e[11]}, {31'h0, r.hit});
  endtask

  task automatic refresh(input logic [47:0] m);
    int n;
    n = 0;
    @(posedge clk);
    src_req_mac <= m;
    src_req_valid <= 1'b1;
    #1;
    while (src_req_ready !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    src_req_valid <= 1'b0;
  endtask

  // Watchdog well beyond the expected few thousand cycles
  initial
  begin
    #200us;
    fails++;
    stop_test;
  end

  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (DEPTH + 4) @(posedge clk);
    for (int i = 0; i < 5; i++)
    begin
      rd(am[i], d);
      chk("reset value", 32'h0, d);
    end
    wr(OFS_UPPER, 32'hffff_ffff);
    rd(OFS_UPPER, d);
    chk("upper reserved bits", 32'h07ff_ffff, d);
    wr(OFS_LOWER, 32'ha5a5_5a5b);
    rd(OFS_LOWER, d);
    chk("lower staging", 32'ha5a5_5a5b, d);
    wr(16'h1234, 32'hffff_ffff);
    rd(16'h1234, d);
    chk("unmapped read", 32'h0, d);
    // Every association code, each make after the first overwriting the same address
    for (int c = 0; c < 8; c++)
    begin
      make(upw(5'h14, 3'h0, c[2:0], 16'hbeef), MAC);
      look(MAC, {4'h8, 3'h0, pm[c]}, 1'b1);
    end
    global_da_pri <= 1'b1;
    make(upw(5'h15, 3'h5, 3'h7, 16'hbeef), MAC);
    look(MAC, {4'h9, 3'h5, 3'h7}, 1'b1);
    global_da_pri <= 1'b0;
    look(MAC, {4'h8, 3'h0, 3'h7}, 1'b1);
    global_da_pri <= 1'b1;
    make(upw(5'h14, 3'h5, 3'h7, 16'hbeef), MAC);
    look(MAC, {4'h8, 3'h0, 3'h7}, 1'b1);
    make(upw(5'h16, 3'h0, 3'h7, 16'hbeef), MAC);
    look(MAC, {4'hc, 3'h0, 3'h7}, 1'b1);
    // Override must show while no port forwards
    port_fwd_state <= 3'h0;
    make(upw(5'h1c, 3'h0, 3'h7, 16'hbeef), MAC);
    look(MAC, {4'ha, 3'h0, 3'h7}, 1'b1);
    // Override still never reaches a disabled port
    port_disabled <= 3'h2;
    look(MAC, {4'ha, 3'h0, 3'h5}, 1'b1);
    port_disabled <= 3'h0;
    port_fwd_state <= 3'h7;
    look({16'h3eef, LO}, 12'h000, 1'b0);
    look({LO[15:0], 16'hbeef, LO[31:16]}, 12'h000, 1'b0);
    make(upw(5'h00, 3'h0, 3'h7, 16'hbeef), MAC);
    look(MAC, 12'h000, 1'b0);
    // Aging: static, refreshed and idle entries, idle one made last
    make(upw(5'h14, 3'h0, 3'h0, 16'h2222), {16'h2222, LO});
    make(upw(5'h1a, 3'h0, 3'h0, 16'h3333), {16'h3333, LO});
    make(upw(5'h1a, 3'h0, 3'h0, 16'h1111), {16'h1111, LO});
    look({16'h1111, LO}, 12'h800, 1'b0);
    for (int k = 0; k < 9; k++)
    begin
      repeat (95) @(posedge clk);
      refresh({16'h3333, LO});
    end
    look({16'h1111, LO}, 12'h000, 1'b0);
    look({16'h2222, LO}, 12'h800, 1'b0);
    look({16'h3333, LO}, 12'h800, 1'b0);
    // Mid-run reset must clear written staging words and the static 2222 entry
    wr(OFS_UPPER, 32'h07ff_ffff);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (DEPTH + 4) @(posedge clk);
    rd(OFS_UPPER, d);
    chk("upper after reset", 32'h0, d);
    rd(OFS_LOWER, d);
    chk("lower after reset", 32'h0, d);
    look({16'h2222, LO}, 12'h000, 1'b0);
    // One make more than the table holds must raise the full flag
    for (int k = 0; k < DEPTH + 1; k++)
      make(upw(5'h14, 3'h0, 3'h7, 16'(k)), {16'(k), LO});
    rd(OFS_STATUS, d);
    chk("table full", 32'h2, d);
    stop_test;
  end
endmodule
